// *** src/tsfl_map.svh ***
// timing constants for the touch sensor fault lockout block
`ifndef TSFL_MAP_SVH
`define TSFL_MAP_SVH
`define TSFL_CLK_HZ 100000000
`define TSFL_SELFTEST_US 1000
`define TSFL_SELFTEST_CYC ((`TSFL_SELFTEST_US * (`TSFL_CLK_HZ / 1000000)))
`define TSFL_PULSE_US 100
`define TSFL_PULSE_CYC ((`TSFL_PULSE_US * (`TSFL_CLK_HZ / 1000000)))
`define TSFL_ECHO_US 10
`define TSFL_ECHO_CYC ((`TSFL_ECHO_US * (`TSFL_CLK_HZ / 1000000)))
`define TSFL_FLASH_MS 250
`define TSFL_FLASH_CYC ((`TSFL_FLASH_MS * (`TSFL_CLK_HZ / 1000)))
`define TSFL_BLOCK_PULSES 3
`endif

// *** src/tsfl_pkg.sv ***
// types for the touch sensor fault lockout block
package tsfl_pkg;
    typedef enum logic [1:0] {
        TSFL_SELFTEST = 2'b00,
        TSFL_RUN = 2'b01,
        TSFL_FAULT = 2'b10
    } tsfl_state_t;
endpackage

// *** src/tsfl_tick.sv ***
// enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module tsfl_tick #(
    parameter int PERIOD = 100
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clear,
    output logic o_tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    initial
    begin
        if (PERIOD < 1)
        begin
            $error("tsfl_tick: PERIOD must be at least 1");
        end
    end

    always_comb
    begin
        if (i_clear || cnt_reg == 32'(PERIOD - 1))
        begin
            cnt_next = 32'h0;
        end
        else
        begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg <= 32'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_tick = !i_clear && (cnt_reg == 32'(PERIOD - 1));
endmodule
`default_nettype wire

// *** src/tsfl_top.sv ***
// touch sensor self-test, run and fault lockout controller
`timescale 1ns/10ps
`default_nettype none
`include "tsfl_map.svh"
module tsfl_top
    import tsfl_pkg::*;
#(
    parameter int SELFTEST_CYC = `TSFL_SELFTEST_CYC,
    parameter int PULSE_CYC = `TSFL_PULSE_CYC,
    parameter int ECHO_CYC = `TSFL_ECHO_CYC,
    parameter int FLASH_CYC = `TSFL_FLASH_CYC,
    parameter int BLOCK_PULSES = `TSFL_BLOCK_PULSES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_rx_light,
    input wire logic i_fault_check,
    output logic o_emitter,
    output logic o_out_no,
    output logic o_out_nc,
    output logic o_led_output,
    output logic o_led_power,
    output var tsfl_pkg::tsfl_state_t o_state
);
    import tsfl_pkg::*;

    // emitter output register plus two receiver synchroniser stages
    localparam int PIPE_CYC = 3;

    initial
    begin
        if (ECHO_CYC < 1 || PULSE_CYC < 2 * (ECHO_CYC + PIPE_CYC) + 2 ||
            SELFTEST_CYC < 2 * PULSE_CYC)
        begin
            $error("tsfl_top: timing parameters inconsistent");
        end
        if (BLOCK_PULSES < 1 || BLOCK_PULSES > 255 || FLASH_CYC < 1)
        begin
            $error("tsfl_top: count parameters out of range");
        end
    end

    // synchronisers for the receiver and the check input
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic chk_s1_reg;
    logic chk_s2_reg;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_s1_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
            chk_s1_reg <= 1'b0;
            chk_s2_reg <= 1'b0;
        end
        else
        begin
            rx_s1_reg <= i_rx_light;
            rx_s2_reg <= rx_s1_reg;
            chk_s1_reg <= i_fault_check;
            chk_s2_reg <= chk_s1_reg;
        end
    end

    tsfl_state_t state_reg;
    tsfl_state_t state_next;
    logic [31:0] phase_reg;
    logic [31:0] phase_next;
    logic [31:0] st_cnt_reg;
    logic [31:0] st_cnt_next;
    logic seen_on_reg;
    logic seen_on_next;
    logic [7:0] miss_reg;
    logic [7:0] miss_next;
    logic blocked_reg;
    logic blocked_next;
    logic st_ok_reg;
    logic st_ok_next;
    logic flash_reg;
    logic flash_next;
    logic flash_tick;
    logic emit_on;
    logic pulse_end;
    logic echo_bad;

    tsfl_tick #(
        .PERIOD(FLASH_CYC)
    ) u_flash (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clear(state_reg != TSFL_FAULT),
        .o_tick(flash_tick)
    );

    // emitter on for the first half of each pulse period
    assign emit_on = phase_reg < 32'(PULSE_CYC / 2);
    assign pulse_end = phase_reg == 32'(PULSE_CYC - 1);
    // receiver seen lit while emitter dark is a mismatch (stuck receiver)
    // the window waits out our own pipeline too, else a healthy echo tail trips it
    assign echo_bad = !emit_on && phase_reg >= 32'(PULSE_CYC / 2 + ECHO_CYC + PIPE_CYC)
        && rx_s2_reg;

    always_comb
    begin
        state_next = state_reg;
        phase_next = pulse_end ? 32'h0 : phase_reg + 32'h1;
        st_cnt_next = st_cnt_reg;
        seen_on_next = seen_on_reg;
        miss_next = miss_reg;
        blocked_next = blocked_reg;
        st_ok_next = st_ok_reg;
        flash_next = flash_reg;
        if (emit_on && phase_reg >= 32'(ECHO_CYC) && rx_s2_reg)
        begin
            seen_on_next = 1'b1;
        end
        if (pulse_end)
        begin
            seen_on_next = 1'b0;
            // BLOCK_PULSES unanswered pulses in a row mean the beam is blocked
            if (seen_on_reg)
            begin
                miss_next = 8'h0;
                blocked_next = 1'b0;
            end
            else if (miss_reg != 8'(BLOCK_PULSES))
            begin
                miss_next = miss_reg + 8'h1;
                if (miss_reg == 8'(BLOCK_PULSES - 1))
                begin
                    blocked_next = 1'b1;
                end
            end
        end
        case (state_reg)
            TSFL_SELFTEST:
            begin
                // self-test demands a lit answer and no stuck receiver
                st_cnt_next = st_cnt_reg + 32'h1;
                if (pulse_end && seen_on_reg)
                begin
                    st_ok_next = 1'b1;
                end
                if (echo_bad || chk_s2_reg)
                begin
                    state_next = TSFL_FAULT;
                end
                else if (st_cnt_reg == 32'(SELFTEST_CYC - 1))
                begin
                    // pass enters run, fail locks out
                    state_next = st_ok_reg ? TSFL_RUN : TSFL_FAULT;
                end
            end
            TSFL_RUN:
            begin
                if (echo_bad || chk_s2_reg)
                begin
                    state_next = TSFL_FAULT;
                end
            end
            TSFL_FAULT:
            begin
                state_next = TSFL_FAULT;
                if (flash_tick)
                begin
                    flash_next = !flash_reg;
                end
            end
            default:
            begin
                state_next = TSFL_FAULT;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= TSFL_SELFTEST;
            phase_reg <= 32'h0;
            st_cnt_reg <= 32'h0;
            seen_on_reg <= 1'b0;
            miss_reg <= 8'h0;
            blocked_reg <= 1'b0;
            st_ok_reg <= 1'b0;
            flash_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            st_cnt_reg <= st_cnt_next;
            seen_on_reg <= seen_on_next;
            miss_reg <= miss_next;
            blocked_reg <= blocked_next;
            st_ok_reg <= st_ok_next;
            flash_reg <= flash_next;
        end
    end

    // output registers keep the pins glitch free
    logic out_no_reg;
    logic out_nc_reg;
    logic led_out_reg;
    logic emit_reg;
    logic pwr_reg;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_no_reg <= 1'b0;
            out_nc_reg <= 1'b1;
            led_out_reg <= 1'b0;
            emit_reg <= 1'b0;
            pwr_reg <= 1'b0;
        end
        else
        begin
            emit_reg <= emit_on;
            pwr_reg <= 1'b1;
            // blocked beam asserts outputs, clear deasserts them
            // pair always opposite, inactive outside run
            out_no_reg <= (state_next == TSFL_RUN) && blocked_next;
            out_nc_reg <= !((state_next == TSFL_RUN) && blocked_next);
            // flashing led in the fault state
            if (state_next == TSFL_FAULT)
            begin
                led_out_reg <= flash_next;
            end
            else
            begin
                led_out_reg <= (state_next == TSFL_RUN) && blocked_next;
            end
        end
    end

    assign o_emitter = emit_reg;
    assign o_out_no = out_no_reg;
    assign o_out_nc = out_nc_reg;
    assign o_led_output = led_out_reg;
    assign o_led_power = pwr_reg;
    assign o_state = state_reg;
endmodule
`default_nettype wire

// *** dv/tsfl_monitor.sv ***
// port checker for the touch sensor fault lockout controller
`timescale 1ns/10ps
`default_nettype none
module tsfl_monitor
    import tsfl_pkg::*;
#(
    parameter int SELFTEST_CYC = 100
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_rx_light,
    input wire logic i_fault_check,
    input wire logic o_emitter,
    input wire logic o_out_no,
    input wire logic o_out_nc,
    input wire logic o_led_output,
    input wire logic o_led_power,
    input wire tsfl_pkg::tsfl_state_t o_state
);
    int age_reg;
    int age_next;
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    // saturates so a long run never wraps
    always_comb age_next = (age_reg < SELFTEST_CYC) ? age_reg + 1 : age_reg;
    always_ff @(posedge i_clock or posedge i_rst)
        if (i_rst)
            age_reg <= 0;
        else
            age_reg <= age_next;
    chk_pair_opposite: assert property (o_out_nc == !o_out_no)
        else $error("output pair not complementary");
    chk_power_on: assert property ($past(!i_rst) |-> o_led_power)
        else $error("power led dark while powered");
    // two cycles of slack; run starts on the same edge that age_reg reaches SELFTEST_CYC
    chk_test_first: assert property (o_state == TSFL_RUN |-> age_reg >= SELFTEST_CYC - 2)
        else $error("run mode before self-test time");
    chk_test_quiet: assert property (o_state == TSFL_SELFTEST |-> !o_out_no)
        else $error("output active in self-test");
    chk_fault_off: assert property (o_state == TSFL_FAULT |-> !o_out_no)
        else $error("output active in fault");
    chk_fault_sticky: assert property (o_state == TSFL_FAULT |=> o_state == TSFL_FAULT)
        else $error("fault state left without reset");
    chk_fault_entry: assert property (
        $rose(i_fault_check) && o_state == TSFL_RUN |-> ##[1:5] o_state == TSFL_FAULT)
        else $error("failed check did not lock out");
    chk_led_follow: assert property (o_state == TSFL_RUN |-> o_led_output == o_out_no)
        else $error("output led disagrees with outputs");
    // the bench sets a flash period of 8 cycles
    chk_flash_period: assert property (
        o_state == TSFL_FAULT && $past(o_state) == TSFL_FAULT && $changed(o_led_output)
        |=> $stable(o_led_output)[*7] ##1 $changed(o_led_output))
        else $error("fault flash period wrong");
    chk_emitter_pulse: assert property (
        o_state == TSFL_RUN |-> ##[1:11] ($changed(o_emitter) || o_state != TSFL_RUN))
        else $error("emitter stopped pulsing");
endmodule
bind tsfl_top tsfl_monitor #(.SELFTEST_CYC(SELFTEST_CYC)) u_tsfl_monitor (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_rx_light(i_rx_light),
    .i_fault_check(i_fault_check),
    .o_emitter(o_emitter),
    .o_out_no(o_out_no),
    .o_out_nc(o_out_nc),
    .o_led_output(o_led_output),
    .o_led_power(o_led_power),
    .o_state(o_state)
);
`default_nettype wire

// *** dv/tsfl_beam.sv ***
// beam and receiver model facing the emitter
`timescale 1ns/10ps
`default_nettype none
module tsfl_beam (
    input wire logic i_clock,
    input wire logic i_emitter,
    input wire logic i_blocked,
    input wire logic i_stray,
    output logic o_rx_light
);
    // receiver echoes each pulse unless the beam is blocked
    // stray light stands for a receiver that answers with the emitter off
    always @(posedge i_clock)
        o_rx_light <= i_stray | (i_emitter & !i_blocked);
endmodule
`default_nettype wire

// *** dv/test_tsfl_top.sv ***
// self-checking bench for the touch sensor fault lockout controller
`timescale 1ns/10ps
`default_nettype none
module test_tsfl_top;
    import tsfl_pkg::*;
    logic i_clock, i_rst, i_fault_check, blocked, stray, rx, prev;
    logic o_emitter, o_out_no, o_out_nc, o_led_output, o_led_power;
    tsfl_state_t o_state;
    int err_count = 0;
    int tests_run = 0;
    int n;
    // {blocked, expected output, expected led}
    logic [2:0] rows [4] = '{3'h0, 3'h7, 3'h0, 3'h7};
    tsfl_beam u_tsfl_beam (.i_clock(i_clock), .i_emitter(o_emitter), .i_blocked(blocked),
        .i_stray(stray), .o_rx_light(rx));
    tsfl_top #(.SELFTEST_CYC(100), .PULSE_CYC(20), .ECHO_CYC(2), .FLASH_CYC(8),
        .BLOCK_PULSES(3)) u_tsfl_top (.i_clock(i_clock), .i_rst(i_rst), .i_rx_light(rx),
        .i_fault_check(i_fault_check), .o_emitter(o_emitter), .o_out_no(o_out_no),
        .o_out_nc(o_out_nc), .o_led_output(o_led_output), .o_led_power(o_led_power),
        .o_state(o_state));
    initial
    begin
        i_clock = 0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: bit %b not %b", $time, got, exp);
        end
    endtask
    task automatic check_state(input tsfl_state_t got, input tsfl_state_t exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: state %b not %b", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_state(input tsfl_state_t exp, input int limit);
        int k;
        k = 0;
        while (o_state !== exp && k < limit)
        begin
            @(negedge i_clock);
            k++;
        end
        check_state(o_state, exp);
        if (o_state !== exp)
            conclude();
    endtask
    task automatic power_cycle();
        i_rst = 1;
        repeat (16) @(negedge i_clock);
        i_rst = 0;
    endtask
    // toggles of the emitter (sel high) or the output led over 40 cycles;
    // 40 is a whole number of both half periods, so the count does not depend on phase
    task automatic toggle_count(input logic sel, input int exp);
        n = 0;
        prev = sel ? o_emitter : o_led_output;
        repeat (40)
        begin
            @(negedge i_clock);
            if ((sel ? o_emitter : o_led_output) !== prev)
                n++;
            prev = sel ? o_emitter : o_led_output;
        end
        check_bit(n == exp, 1'b1);
    endtask
    initial
    begin
        i_rst = 1;
        i_fault_check = 0;
        blocked = 0;
        stray = 0;
        repeat (16) @(negedge i_clock);
        check_bit(o_out_nc, 1'b1);
        check_bit(o_led_power, 1'b0);
        i_rst = 0;
        wait_state(TSFL_RUN, 300);
        // half pulse period of 10 cycles gives 4 emitter toggles
        toggle_count(1'b1, 4);
        foreach (rows[i])
        begin
            blocked = rows[i][2];
            repeat (120) @(negedge i_clock);
            check_bit(o_out_no, rows[i][1]);
            check_bit(o_out_nc, !rows[i][1]);
            check_bit(o_led_output, rows[i][0]);
            check_bit(o_led_power, 1'b1);
        end
        i_fault_check = 1;
        wait_state(TSFL_FAULT, 8);
        check_bit(o_out_no, 1'b0);
        // flash period of 8 cycles gives 5 led toggles
        toggle_count(1'b0, 5);
        i_fault_check = 0;
        repeat (100) @(negedge i_clock);
        check_state(o_state, TSFL_FAULT);
        check_bit(o_out_nc, 1'b1);
        power_cycle();
        check_state(o_state, TSFL_SELFTEST);
        wait_state(TSFL_FAULT, 300);
        check_bit(o_out_no, 1'b0);
        toggle_count(1'b0, 5);
        blocked = 0;
        power_cycle();
        wait_state(TSFL_RUN, 300);
        stray = 1;
        wait_state(TSFL_FAULT, 60);
        conclude();
    end
endmodule
`default_nettype wire
